// *** rtl/conv_ctrl_pkg.sv ***
// Constants, field layouts and carrier types for the converter command block.
// Assumes a 16-bit framed serial command word, MSB first.
package conv_ctrl_pkg;

    localparam int WORD_W      = 16;
    localparam int DATA_W      = 12;
    localparam int CH_W        = 3;
    localparam int NUM_CH      = 8;
    localparam int SEQ_W       = 9;
    localparam int CODE_W      = 4;
    localparam int BIT_CNT_W   = 5;
    localparam int FIFO_DEPTH  = 16;

    // Command word fields
    localparam int CMD_BIT     = 15;
    localparam int ADDR_HI     = 14;
    localparam int ADDR_LO     = 11;
    localparam int CH_HI       = 14;
    localparam int CH_LO       = 12;
    localparam int DATA_HI     = 11;

    // Control register addresses
    localparam logic [3:0] ADDR_READBACK  = 4'h1;
    localparam logic [3:0] ADDR_SEQUENCE  = 4'h2;
    localparam logic [3:0] ADDR_ADC_PINS  = 4'h4;
    localparam logic [3:0] ADDR_LOAD_MODE = 4'h7;
    localparam logic [3:0] ADDR_GPIO_OCFG = 4'h8;

    // Readback control fields
    localparam int RB_EN_HI    = 4;
    localparam int RB_EN_LO    = 3;
    localparam int RB_CH_HI    = 2;
    localparam logic [1:0] RB_ENABLE  = 2'b11;
    localparam logic [1:0] RB_DISABLE = 2'b00;

    // Sequence, pin select, output configuration and load mode fields
    localparam int SEQ_REP_BIT  = 9;
    localparam int SEQ_TEMP_BIT = 8;
    localparam int PIN_SEL_HI   = 7;
    localparam int BUSY_EN_BIT  = 8;
    localparam int PIN7_OUT_BIT = 7;
    localparam int LOAD_MODE_HI = 1;

    localparam logic [1:0] LOAD_IMMEDIATE = 2'b00;
    localparam logic [1:0] LOAD_HOLD      = 2'b01;
    localparam logic [1:0] LOAD_ALL       = 2'b10;

    // Reset values
    localparam logic [7:0] PIN_SEL_RST   = 8'h00;
    localparam logic [1:0] LOAD_MODE_RST = 2'b00;

    typedef struct packed {
        logic [CH_W-1:0]   ch;
        logic [DATA_W-1:0] data;
    } dac_update_s;

    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic sdi;
    } spi_pins_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RUN,
        SEQ_DRAIN
    } seq_e;

endpackage

// *** rtl/stream_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
module stream_fifo #(
    parameter int W     = 15,
    parameter int DEPTH = 16
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    // Extra pointer bit tells full from empty
    assign empty       = (wr_ptr == rd_ptr);
    assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_ptr[AW-1:0]];
    assign push        = i_in_valid && !full;
    assign pop         = i_out_ready && !empty;

    always_ff @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule

// *** rtl/dac_adc_cmd_seq.sv ***
// Serial command logic: DAC writes, DAC readback, ADC sequencing, busy pin.
// Assumes the serial pins are asynchronous to i_core_clk and much slower.
module dac_adc_cmd_seq
    import conv_ctrl_pkg::*;
(
    input  wire logic                          i_core_clk,
    input  wire logic                          i_rst_n,
    input  wire conv_ctrl_pkg::spi_pins_s      i_spi,
    output logic                               o_sdo,
    output logic                               o_sdo_oe,
    output logic                               o_mfp7,
    output logic                               o_mfp7_oe,
    output logic [7:0]                         o_adc_pin_select,
    output logic                               o_conv_start,
    output logic [conv_ctrl_pkg::CODE_W-1:0]   o_conv_code,
    input  wire logic                          i_conv_done,
    input  wire logic [conv_ctrl_pkg::DATA_W-1:0] i_conv_result,
    output conv_ctrl_pkg::dac_update_s         o_dac_update,
    output logic                               o_dac_update_valid,
    input  wire logic                          i_dac_update_ready
);
    import conv_ctrl_pkg::*;

    // Lowest enabled sequence slot at or above a start point
    function automatic logic [CODE_W:0] find_from(input logic [SEQ_W-1:0] mask,
                                                  input logic [CODE_W-1:0] from);
        logic [CODE_W:0] r;
        r = '0;
        for (int i = SEQ_W - 1; i >= 0; i--)
        begin
            if (mask[i] && (CODE_W'(i) >= from))
            begin
                r = {1'b1, CODE_W'(i)};
            end
        end
        return r;
    endfunction

    spi_pins_s            s1;
    spi_pins_s            s2;
    spi_pins_s            s3;
    spi_pins_s            flt;
    spi_pins_s            prev;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 frame_start;
    logic                 frame_end;
    logic                 in_frame;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [WORD_W-1:0]    rx;
    logic                 word_ok;
    logic                 is_ctrl;
    logic [3:0]           addr;
    logic [WORD_W-1:0]    tx_sh;
    logic                 tx_drive;
    logic                 rb_pend;
    logic [CH_W-1:0]      rb_ch;
    logic [DATA_W-1:0]    input_regs [NUM_CH];
    logic [NUM_CH-1:0]    pend_upd;
    logic [NUM_CH-1:0]    upd_set;
    logic [NUM_CH-1:0]    upd_clr;
    logic [CH_W-1:0]      upd_ch;
    logic                 fifo_in_ready;
    logic [1:0]           load_mode;
    logic                 busy_en;
    logic                 pin7_out;
    seq_e                 seq_state;
    logic [SEQ_W-1:0]     seq_mask;
    logic                 seq_rep;
    logic [CODE_W-1:0]    cur_code;
    logic [CODE_W:0]      next_slot;
    logic [CODE_W:0]      first_slot;
    logic [CODE_W:0]      wr_slot;
    logic                 conv_busy;
    logic                 result_valid;
    logic [WORD_W-1:0]    result_word;
    dac_update_s          fifo_in;

    // Three-stage synchronisers; a level changes once stages two and three agree
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1   <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
            s2   <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
            s3   <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
            flt  <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
            prev <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
        end
        else
        begin
            s1   <= i_spi;
            s2   <= s1;
            s3   <= s2;
            flt  <= flt ^ ((s2 ~^ s3) & (s3 ^ flt));
            prev <= flt;
        end
    end

    assign sclk_rise   = flt.sclk && !prev.sclk;
    assign sclk_fall   = !flt.sclk && prev.sclk;
    assign frame_start = !flt.sync_n && prev.sync_n;
    assign frame_end   = flt.sync_n && !prev.sync_n;
    assign in_frame    = !flt.sync_n;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_cnt <= '0;
            rx      <= '0;
        end
        else if (frame_start)
        begin
            bit_cnt <= '0;
        end
        else if (in_frame && sclk_fall && (bit_cnt != BIT_CNT_W'(WORD_W)))
        begin
            rx      <= {rx[WORD_W-2:0], flt.sdi};
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // Short frames are dropped whole; long frames keep their first 16 bits
    assign word_ok = frame_end && (bit_cnt == BIT_CNT_W'(WORD_W));
    assign is_ctrl = word_ok && !rx[CMD_BIT];
    assign addr    = rx[ADDR_HI:ADDR_LO];

    // Result or readback word loaded at select fall, MSB first
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_sh    <= '0;
            tx_drive <= 1'b0;
        end
        else if (frame_start)
        begin
            if (result_valid)
            begin
                tx_sh    <= result_word;
                tx_drive <= 1'b1;
            end
            // Readback goes out on the next frame
            else if (rb_pend)
            begin
                tx_sh    <= {1'b1, rb_ch, input_regs[rb_ch]};
                tx_drive <= 1'b1;
            end
            else
            begin
                tx_sh    <= '0;
                tx_drive <= 1'b0;
            end
        end
        else if (in_frame && sclk_rise)
        begin
            tx_sh <= {tx_sh[WORD_W-2:0], 1'b0};
        end
    end

    // Pin released whenever nothing is being sent
    assign o_sdo    = tx_sh[WORD_W-1];
    assign o_sdo_oe = in_frame && tx_drive;

    // Readback control; a pending request is one-shot
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rb_pend <= 1'b0;
            rb_ch   <= '0;
        end
        else if (is_ctrl && (addr == ADDR_READBACK))
        begin
            // Enable on 11, disable on 00
            if (rx[RB_EN_HI:RB_EN_LO] == RB_ENABLE)
            begin
                rb_pend <= 1'b1;
                rb_ch   <= rx[RB_CH_HI:0];
            end
            else if (rx[RB_EN_HI:RB_EN_LO] == RB_DISABLE)
            begin
                rb_pend <= 1'b0;
            end
        end
        else if (frame_start)
        begin
            rb_pend <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (word_ok && rx[CMD_BIT])
        begin
            input_regs[rx[CH_HI:CH_LO]] <= rx[DATA_HI:0];
        end
    end

    // Load mode decides which channels must be copied out
    always_comb
    begin
        upd_set = '0;
        if (word_ok && rx[CMD_BIT] && (load_mode == LOAD_IMMEDIATE))
        begin
            upd_set[rx[CH_HI:CH_LO]] = 1'b1;
        end
        else if (is_ctrl && (addr == ADDR_LOAD_MODE)
                 && (rx[LOAD_MODE_HI:0] == LOAD_ALL))
        begin
            upd_set = '1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            load_mode <= LOAD_MODE_RST;
        end
        else if (is_ctrl && (addr == ADDR_LOAD_MODE))
        begin
            load_mode <= (rx[LOAD_MODE_HI:0] == LOAD_ALL) ? LOAD_HOLD
                                                         : rx[LOAD_MODE_HI:0];
        end
    end

    // Pending copies wait on a full FIFO; a new set wins over the clear
    always_comb
    begin
        upd_ch  = '0;
        upd_clr = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (pend_upd[i])
            begin
                upd_ch = CH_W'(i);
            end
        end
        if (fifo_in_ready && (pend_upd != '0))
        begin
            upd_clr[upd_ch] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pend_upd <= '0;
        end
        else
        begin
            pend_upd <= (pend_upd & ~upd_clr) | upd_set;
        end
    end

    assign fifo_in = '{ch: upd_ch, data: input_regs[upd_ch]};

    stream_fifo #(
        .W     ($bits(dac_update_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_update_fifo (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (pend_upd != '0),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in),
        .o_out_valid (o_dac_update_valid),
        .i_out_ready (i_dac_update_ready),
        .o_out_data  (o_dac_update)
    );

    // ADC pin select and busy-pin configuration
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_adc_pin_select <= PIN_SEL_RST;
            busy_en          <= 1'b0;
            pin7_out         <= 1'b0;
        end
        else if (is_ctrl && (addr == ADDR_ADC_PINS))
        begin
            o_adc_pin_select <= rx[PIN_SEL_HI:0];
        end
        else if (is_ctrl && (addr == ADDR_GPIO_OCFG))
        begin
            busy_en  <= rx[BUSY_EN_BIT];
            pin7_out <= rx[PIN7_OUT_BIT];
        end
    end

    // Busy drives the pin only with both bits set
    assign o_mfp7_oe = busy_en && pin7_out;

    assign next_slot  = find_from(seq_mask, cur_code + 1'b1);
    assign first_slot = find_from(seq_mask, '0);
    assign wr_slot    = find_from(rx[SEQ_TEMP_BIT:0], '0);

    // Sequencer: in SEQ_RUN each select fall starts the current slot
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            seq_state    <= SEQ_IDLE;
            seq_mask     <= '0;
            seq_rep      <= 1'b0;
            cur_code     <= '0;
            o_conv_start <= 1'b0;
            o_conv_code  <= '0;
        end
        else
        begin
            o_conv_start <= 1'b0;
            if (is_ctrl && (addr == ADDR_SEQUENCE))
            begin
                seq_mask <= rx[SEQ_TEMP_BIT:0];
                seq_rep  <= rx[SEQ_REP_BIT];
                cur_code <= wr_slot[CODE_W-1:0];
                // All-zero write stops; repeat alone has nothing to run
                seq_state <= wr_slot[CODE_W] ? SEQ_RUN : SEQ_IDLE;
            end
            else if (frame_start)
            begin
                case (seq_state)
                    SEQ_RUN:
                    begin
                        o_conv_start <= 1'b1;
                        o_conv_code  <= cur_code;
                        if (next_slot[CODE_W])
                        begin
                            cur_code <= next_slot[CODE_W-1:0];
                        end
                        // Wrap on repeat, else drain last result
                        else if (seq_rep)
                        begin
                            cur_code <= first_slot[CODE_W-1:0];
                        end
                        else
                        begin
                            seq_state <= SEQ_DRAIN;
                        end
                    end
                    SEQ_DRAIN:
                    begin
                        seq_state <= SEQ_IDLE;
                    end
                    default:
                    begin
                        seq_state <= SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    // Busy low from start until the result is held
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            conv_busy    <= 1'b0;
            o_mfp7       <= 1'b1;
            result_valid <= 1'b0;
            result_word  <= '0;
        end
        else
        begin
            if (o_conv_start)
            begin
                conv_busy <= 1'b1;
                o_mfp7    <= 1'b0;
            end
            else if (conv_busy && i_conv_done)
            begin
                conv_busy <= 1'b0;
                o_mfp7    <= 1'b1;
            end
            // Result word; a fresh result wins over the load
            if (conv_busy && i_conv_done)
            begin
                result_valid <= 1'b1;
                result_word  <= {o_conv_code, i_conv_result};
            end
            else if (frame_start)
            begin
                result_valid <= 1'b0;
            end
        end
    end

    property p_conv_on_fall;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (frame_start && (seq_state == SEQ_RUN) && !is_ctrl) |=> o_conv_start ##1 !o_mfp7;
    endproperty
    a_conv_on_fall: assert property (p_conv_on_fall) else $error("no conversion at select fall");

    property p_busy_release;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (conv_busy && i_conv_done) |=> (o_mfp7 && result_valid && (result_word[DATA_HI:0] == $past(i_conv_result)));
    endproperty
    a_busy_release: assert property (p_busy_release) else $error("busy or result not updated");

    property p_result_out;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (frame_start && result_valid) |=> (tx_sh == $past(result_word)) && tx_drive;
    endproperty
    a_result_out: assert property (p_result_out) else $error("result not loaded for shift");

    property p_readback_word;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (frame_start && rb_pend && !result_valid)
        |=> tx_sh[WORD_W-1] && (tx_sh[CH_HI:CH_LO] == $past(rb_ch)) && !rb_pend;
    endproperty
    a_readback_word: assert property (p_readback_word) else $error("bad readback word");

    property p_slot_enabled;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_conv_start |-> seq_mask[o_conv_code];
    endproperty
    a_slot_enabled: assert property (p_slot_enabled) else $error("converted a disabled slot");

    property p_drain_stops;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (frame_start && (seq_state == SEQ_DRAIN) && !is_ctrl)
        |=> (seq_state == SEQ_IDLE) && !o_conv_start;
    endproperty
    a_drain_stops: assert property (p_drain_stops) else $error("sequence did not stop");

    property p_rb_disable;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (is_ctrl && (addr == ADDR_READBACK) && (rx[RB_EN_HI:RB_EN_LO] == RB_DISABLE)) |=> !rb_pend;
    endproperty
    a_rb_disable: assert property (p_rb_disable) else $error("readback not disabled");

    property p_load_all;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (is_ctrl && (addr == ADDR_LOAD_MODE) && (rx[LOAD_MODE_HI:0] == LOAD_ALL))
        |=> (load_mode == LOAD_HOLD) && (pend_upd == '1);
    endproperty
    a_load_all: assert property (p_load_all) else $error("load-all not applied");

    property p_pin_select;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (is_ctrl && (addr == ADDR_ADC_PINS)) |=> (o_adc_pin_select == $past(rx[PIN_SEL_HI:0]));
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("pin select not loaded");

    property p_dac_write;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (word_ok && rx[CMD_BIT]) |=> (input_regs[$past(rx[CH_HI:CH_LO])] == $past(rx[DATA_HI:0]));
    endproperty
    a_dac_write: assert property (p_dac_write) else $error("DAC input register not written");

endmodule

// *** tb/host_spi_model.sv ***
// Host serial master model: framed 16-bit words, clock idles high.
// Assumes calls from the bench; pins change on core falling edges.
module host_spi_model
    import conv_ctrl_pkg::*;
(
    input  wire logic                 i_core_clk,
    input  wire logic                 i_sdo,
    input  wire logic                 i_sdo_oe,
    output conv_ctrl_pkg::spi_pins_s  o_spi,
    output logic [16:0]               o_rx,
    output logic                      o_rx_stb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv;
    initial
    begin
        o_spi = '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
        o_rx = '0;
        o_rx_stb = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic xfer(input logic [15:0] w);
        drv = 1'b1;
        o_spi.sync_n = 1'b0;
        wait_cyc(8);
        for (int i = 15; i >= 0; i--)
        begin
            o_spi.sdi = w[i];
            wait_cyc(4);
            o_spi.sclk = 1'b0;
            wait_cyc(4);
            // Output moves late after a rise; sample just before the next
            o_rx[i] = i_sdo;
            drv = drv & i_sdo_oe;
            o_spi.sclk = 1'b1;
        end
        wait_cyc(8);
        o_spi.sync_n = 1'b1;
        o_spi.sdi = ~o_spi.sdi;
        // Undriven frame reads as zero, flag bit clear
        o_rx = drv ? {1'b1, o_rx[15:0]} : 17'h0;
        o_rx_stb = 1'b1;
        wait_cyc(1);
        o_rx_stb = 1'b0;
        wait_cyc(7);
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the converter command block.
// Assumes the host model drives the pins; the bench plays the converter.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_ctrl_pkg::*;
    logic              clk;
    logic              rst_n;
    logic              done;
    logic              ready;
    logic [DATA_W-1:0] result;
    logic [11:0]       res [8];
    logic [11:0]       dac [8];
    spi_pins_s         spi;
    dac_update_s       upd;
    logic              upd_valid;
    logic              sdo;
    logic              sdo_oe;
    logic              mfp7;
    logic              mfp7_oe;
    logic [7:0]        pins;
    logic              start;
    logic [CODE_W-1:0] code;
    logic [16:0]       rx;
    logic              rx_stb;
    int                failures;
    int                cmp_count;
    int                e;
    int                rx_q[$];
    dac_update_s       upd_q[$];

    dac_adc_cmd_seq i_dut (
        .i_core_clk         (clk),
        .i_rst_n            (rst_n),
        .i_spi              (spi),
        .o_sdo              (sdo),
        .o_sdo_oe           (sdo_oe),
        .o_mfp7             (mfp7),
        .o_mfp7_oe          (mfp7_oe),
        .o_adc_pin_select   (pins),
        .o_conv_start       (start),
        .o_conv_code        (code),
        .i_conv_done        (done),
        .i_conv_result      (result),
        .o_dac_update       (upd),
        .o_dac_update_valid (upd_valid),
        .i_dac_update_ready (ready)
    );
    host_spi_model i_host (
        .i_core_clk (clk),
        .i_sdo      (sdo),
        .i_sdo_oe   (sdo_oe),
        .o_spi      (spi),
        .o_rx       (rx),
        .o_rx_stb   (rx_stb)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic int word(input int c);
        return int'({2'b10, 3'(c), res[c]});
    endfunction

    initial ready = 1'b1;
    // Consumer stalls at random
    always @(negedge clk) ready = ($urandom % 4) != 0;

    always @(posedge clk)
    begin
        if (upd_valid && ready)
            chk(17'(upd), upd_q.size() > 0 ? 17'(upd_q.pop_front()) : 17'h1ffff);
        if (rx_stb)
        begin
            e = rx_q.size() > 0 ? rx_q.pop_front() : 1;
            if (e >= 0)
                chk(rx, 17'(e));
        end
    end

    // Converter stand-in; result drawn at each start
    always @(negedge clk)
    begin
        if (start)
        begin
            res[code[2:0]] = 12'($urandom);
            @(negedge clk);
            chk(17'(mfp7), 17'h0);
            repeat (8) @(negedge clk);
            result = res[code[2:0]];
            done = 1'b1;
            @(negedge clk);
            done = 1'b0;
            repeat (2) @(negedge clk);
            chk(17'(mfp7), 17'h1);
        end
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        int seq[3];
        logic [7:0] v;
        seq = '{1, 3, 1};
        failures = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        done = 1'b0;
        result = '0;
        void'($urandom(31800));
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(17'(mfp7_oe), 17'h0);
        for (int i = 0; i < 8; i++)
        begin
            dac[i] = 12'($urandom);
            upd_q.push_back({3'(i), dac[i]});
            rx_q.push_back(0);
            i_host.xfer({1'b1, 3'(i), dac[i]});
        end
        for (int i = 0; i < 8; i++)
        begin
            rx_q.push_back(0);
            i_host.xfer(16'h0818 | 16'(i));
            rx_q.push_back(int'({2'b11, 3'(i), dac[i]}));
            i_host.xfer(16'h0000);
        end
        // hold mode keeps the write back, load-all copies all eight
        rx_q.push_back(0);
        i_host.xfer(16'h3801);
        dac[2] = 12'($urandom);
        rx_q.push_back(0);
        i_host.xfer({4'ha, dac[2]});
        for (int i = 0; i < 8; i++)
            upd_q.push_back({3'(i), dac[i]});
        rx_q.push_back(0);
        i_host.xfer(16'h3802);
        v = 8'($urandom);
        rx_q.push_back(0);
        i_host.xfer({8'h20, v});
        chk(17'(pins), 17'(v));
        rx_q.push_back(0);
        i_host.xfer(16'h4180);
        chk(17'(mfp7_oe), 17'h1);
        rx_q.push_back(-1);
        i_host.xfer(16'h120a);
        repeat (63) @(negedge clk);
        rx_q.push_back(0);
        i_host.xfer(16'h0000);
        // last frame of the loop stops the sequence
        for (int k = 0; k < 3; k++)
        begin
            rx_q.push_back(word(seq[k]));
            i_host.xfer(k == 2 ? 16'h1000 : 16'h0000);
        end
        repeat (250) @(negedge clk);
        // Conversion launched by the stop frame still goes out once
        rx_q.push_back(word(3));
        i_host.xfer(16'h0000);
        rx_q.push_back(-1);
        i_host.xfer(16'h1020);
        repeat (63) @(negedge clk);
        rx_q.push_back(0);
        i_host.xfer(16'h0000);
        rx_q.push_back(word(5));
        i_host.xfer(16'h0000);
        rx_q.push_back(0);
        i_host.xfer(16'h0000);
        repeat (20) @(negedge clk);
        chk(17'(upd_q.size() + rx_q.size()), 17'h0);
        tally_and_finish();
    end
endmodule
